// *** design/emulated_phy_cfg.svh ***
// offsets, field positions and reset values for the emulated phy control block
`ifndef EMULATED_PHY_CFG_SVH
`define EMULATED_PHY_CFG_SVH

// ==========================================
// register offsets
`define PORT1_CTRL_OFFSET 12'h0C0
`define PORT0_CTRL_OFFSET 12'h1C0
`define MGMT_CTRL_INDEX   5'h00

// ==========================================
// bit positions
`define BIT_SOFT_RESET    15
`define BIT_LOOP          14
`define BIT_SPEED_LOW     13
`define BIT_NEG_ENABLE    12
`define BIT_POWER_DOWN    11
`define BIT_ISOLATE       10
`define BIT_NEG_RESTART   9
`define BIT_DUPLEX        8
`define BIT_COL_TEST      7

// ==========================================
// reset and fixed values
`define CTRL_RESET_VALUE  16'h1000
`define CTRL_WRITE_MASK   16'h7D80
`define PAD_VALUE         16'h0000
`define NEG_SPEED_RESULT  1'h1
`define NEG_DUPLEX_RESULT 1'h1

`endif

// *** design/emulated_phy_pkg.sv ***
// types shared by the emulated phy control block
package emulated_phy_pkg;

    typedef struct packed {
        logic        loop_enable;
        logic        speed_select_low;
        logic        negotiation_enable;
        logic        unused_power_down;
        logic        pin_isolate;
        logic        duplex_select;
        logic        collision_test_enable;
    } ctrl_fields_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } link_mode_t;

    typedef enum logic [1:0] {
        NEG_IDLE = 2'b01,
        NEG_LOAD = 2'b10
    } neg_state_t;

endpackage

// *** design/emulated_phy_control.sv ***
// basic control register of one emulated phy port with its datapath effects
// ==========================================
// Summary of operation
// - writing the soft reset bit restores defaults; the bit self clears
// - loopback returns mac transmit to its receive path, not the fabric
// - with negotiation off, speed low bit picks 10 or 100/200 Mbps
// - negotiation enable resets to one and overrides speed and duplex
// - in mac modes with negotiation on, duplex follows its input pin; speed follows its pin only in rmii mode, else the speed low bit
// - power down bit is stored and read back with no effect
// - isolate in phy mode releases outputs, pulls, and ignores inputs
// - in mac mode the isolate bit is ignored
// - management data pin keeps working while isolated
// - restart negotiation recomputes emulated results and self clears
// - with negotiation off, duplex bit selects half or full duplex
// - collision test asserts collision while the mac transmits
// - speed select high reads zero; writes ignored
// - upper sixteen bits of the mapped view read as fixed padding
// - management access sees a sixteen bit register at index zero
// - management access answers only at the strapped phy address
`timescale 1ns/10ps
`include "emulated_phy_cfg.svh"

module emulated_phy_control #(
    parameter logic [11:0] PORT_OFFSET = `PORT0_CTRL_OFFSET
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    // memory mapped register port
    input  wire logic [11:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    // management serial port, already deserialised
    input  wire logic [4:0]  i_mgmt_phy_addr,
    input  wire logic [4:0]  i_mgmt_reg_index,
    input  wire logic        i_mgmt_wr,
    input  wire logic        i_mgmt_rd,
    input  wire logic [15:0] i_mgmt_wdata,
    output logic      [15:0] o_mgmt_rdata,
    output logic             o_mgmt_rd_valid,
    input  wire logic [4:0]  i_phy_addr_strap,
    input  wire logic        i_mgmt_data_in,
    output logic             o_mgmt_data_out,
    output logic             o_mgmt_data_oe,
    input  wire logic        i_mgmt_drive,
    // port mode
    input  wire logic        i_mac_mode,
    input  wire logic        i_rmii_mode,
    input  wire logic        i_pin_duplex,
    input  wire logic        i_pin_speed,
    // mac facing data path
    input  wire logic [3:0]  i_mac_txd,
    input  wire logic        i_mac_tx_en,
    output logic      [3:0]  o_mac_rxd,
    output logic             o_mac_rx_dv,
    output logic             o_mac_col,
    output logic             o_mac_out_oe,
    output logic             o_pull_enable,
    // fabric side
    output logic      [3:0]  o_fabric_txd,
    output logic             o_fabric_tx_en,
    input  wire logic [3:0]  i_fabric_rxd,
    input  wire logic        i_fabric_rx_dv,
    // resolved link mode
    output emulated_phy_pkg::link_mode_t o_link_mode
);

    // ==========================================
    // register state
    emulated_phy_pkg::ctrl_fields_t ctrl;
    emulated_phy_pkg::ctrl_fields_t next_ctrl;
    emulated_phy_pkg::link_mode_t   neg_result;
    emulated_phy_pkg::link_mode_t   next_link;
    emulated_phy_pkg::neg_state_t   neg_state;
    logic                           reset_pulse;
    logic                           restart_pulse;
    logic                           rd_valid_q;
    wire  [15:0]                    read_value;

    function automatic emulated_phy_pkg::ctrl_fields_t unpack_ctrl(input logic [15:0] v);
        unpack_ctrl = '{
            loop_enable:           v[`BIT_LOOP],
            speed_select_low:      v[`BIT_SPEED_LOW],
            negotiation_enable:    v[`BIT_NEG_ENABLE],
            unused_power_down:     v[`BIT_POWER_DOWN],
            pin_isolate:           v[`BIT_ISOLATE],
            duplex_select:         v[`BIT_DUPLEX],
            collision_test_enable: v[`BIT_COL_TEST]
        };
    endfunction

    // ==========================================
    // access decode
    wire        bus_hit    = (i_reg_addr == PORT_OFFSET);
    wire        bus_wr     = bus_hit & i_reg_wr;
    wire        mgmt_hit   = (i_mgmt_phy_addr == i_phy_addr_strap) &
                             (i_mgmt_reg_index == `MGMT_CTRL_INDEX);
    wire        mgmt_wr    = mgmt_hit & i_mgmt_wr;
    wire        any_wr     = bus_wr | mgmt_wr;
    // bus write takes priority if both land in one cycle
    wire [15:0] wr_value   = bus_wr ? i_reg_wdata[15:0] : i_mgmt_wdata;
    wire [15:0] wr_masked  = wr_value & `CTRL_WRITE_MASK;
    wire        wr_reset   = any_wr & wr_value[`BIT_SOFT_RESET];
    wire        wr_restart = any_wr & wr_value[`BIT_NEG_RESTART];

    // self clearing bits are one-cycle pulses, so they always read zero
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_reset)
        begin
            next_ctrl = unpack_ctrl(`CTRL_RESET_VALUE);
        end
        else if (any_wr)
        begin
            next_ctrl = unpack_ctrl(wr_masked);
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            ctrl          <= unpack_ctrl(`CTRL_RESET_VALUE);
            reset_pulse   <= 1'b0;
            restart_pulse <= 1'b0;
        end
        else
        begin
            ctrl          <= next_ctrl;
            reset_pulse   <= wr_reset;
            restart_pulse <= wr_restart & ~wr_reset;
        end
    end

    // ==========================================
    // emulated negotiation: results reloaded on reset or restart
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            neg_state  <= emulated_phy_pkg::NEG_LOAD;
            neg_result <= '{speed_100: 1'b0, full_duplex: 1'b0};
        end
        else
        begin
            unique case (neg_state)
                emulated_phy_pkg::NEG_IDLE:
                begin
                    if (restart_pulse | reset_pulse)
                    begin
                        neg_state <= emulated_phy_pkg::NEG_LOAD;
                    end
                end
                emulated_phy_pkg::NEG_LOAD:
                begin
                    neg_result <= '{speed_100: `NEG_SPEED_RESULT,
                                    full_duplex: `NEG_DUPLEX_RESULT};
                    neg_state  <= emulated_phy_pkg::NEG_IDLE;
                end
                default:
                begin
                    neg_state <= emulated_phy_pkg::NEG_LOAD;
                end
            endcase
        end
    end

    // ==========================================
    // speed and duplex resolution
    wire mac_speed = i_rmii_mode ? i_pin_speed : ctrl.speed_select_low;
    always_comb
    begin
        next_link = '{speed_100: ctrl.speed_select_low,
                      full_duplex: ctrl.duplex_select};
        if (ctrl.negotiation_enable)
        begin
            if (i_mac_mode)
            begin
                next_link = '{speed_100: mac_speed, full_duplex: i_pin_duplex};
            end
            else
            begin
                next_link = neg_result;
            end
        end
    end

    // ==========================================
    // data path: loopback, isolation, collision test
    // isolation only applies to phy mode pins
    wire isolated  = ctrl.pin_isolate & ~i_mac_mode;
    wire tx_en_in  = i_mac_tx_en & ~isolated;
    wire [3:0] txd_in = isolated ? 4'h0 : i_mac_txd;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            o_link_mode    <= '{speed_100: 1'b0, full_duplex: 1'b0};
            o_mac_rxd      <= 4'h0;
            o_mac_rx_dv    <= 1'b0;
            o_mac_col      <= 1'b0;
            o_fabric_txd   <= 4'h0;
            o_fabric_tx_en <= 1'b0;
            o_reg_rdata    <= 32'h0000_0000;
            o_mgmt_rdata   <= 16'h0000;
        end
        else
        begin
            o_link_mode    <= next_link;
            o_mac_rxd      <= ctrl.loop_enable ? txd_in : i_fabric_rxd;
            o_mac_rx_dv    <= ctrl.loop_enable ? tx_en_in : i_fabric_rx_dv;
            o_mac_col      <= ctrl.collision_test_enable & tx_en_in;
            o_fabric_txd   <= ctrl.loop_enable ? 4'h0 : txd_in;
            o_fabric_tx_en <= tx_en_in & ~ctrl.loop_enable;
            o_reg_rdata    <= (bus_hit & i_reg_rd) ? {`PAD_VALUE, read_value}
                                                   : 32'h0000_0000;
            o_mgmt_rdata   <= (mgmt_hit & i_mgmt_rd) ? read_value : 16'h0000;
        end
    end

    // ==========================================
    // read view and pins
    assign read_value = {1'b0, ctrl.loop_enable, ctrl.speed_select_low,
                         ctrl.negotiation_enable, ctrl.unused_power_down,
                         ctrl.pin_isolate, 1'b0, ctrl.duplex_select,
                         ctrl.collision_test_enable, 7'h00};

    assign o_mgmt_rd_valid = rd_valid_q;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= mgmt_hit & i_mgmt_rd;
        end
    end

    // management pin ignores isolation on purpose
    assign o_mgmt_data_out = i_mgmt_data_in;
    assign o_mgmt_data_oe  = i_mgmt_drive;
    assign o_mac_out_oe    = ~isolated;
    assign o_pull_enable   = ~isolated;

endmodule

// *** sim/emulated_phy_control_monitor.sv ***
// port-level assertions for the emulated phy control block
`timescale 1ns/10ps
module emulated_phy_control_monitor #(
    parameter logic [11:0] PORT_OFFSET = 12'h1C0
) (
    input wire logic        i_ref_clk,
    input wire logic        i_resetn,
    input wire logic [11:0] i_reg_addr,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic [4:0]  i_mgmt_phy_addr,
    input wire logic [4:0]  i_mgmt_reg_index,
    input wire logic        i_mgmt_rd,
    input wire logic [15:0] o_mgmt_rdata,
    input wire logic        o_mgmt_rd_valid,
    input wire logic [4:0]  i_phy_addr_strap,
    input wire logic        i_mgmt_data_in,
    input wire logic        o_mgmt_data_out,
    input wire logic        o_mgmt_data_oe,
    input wire logic        i_mgmt_drive,
    input wire logic        i_mac_mode,
    input wire logic        o_mac_out_oe,
    input wire logic        o_pull_enable,
    input wire logic        o_mac_col,
    input wire logic        o_mac_rx_dv
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    wire mg_hit = i_mgmt_rd && i_mgmt_phy_addr == i_phy_addr_strap && i_mgmt_reg_index == 5'h00;
    // ==========================================
    // assertions
    AST_MDIO_PASS: assert property (o_mgmt_data_out == i_mgmt_data_in && o_mgmt_data_oe == i_mgmt_drive) else $error("mdio pass-through broken");
    AST_MAC_NO_ISO: assert property (i_mac_mode |-> o_mac_out_oe && o_pull_enable) else $error("isolate acted in mac mode");
    AST_RDV_CAUSE: assert property (o_mgmt_rd_valid |-> $past(mg_hit)) else $error("mgmt answer without hit");
    AST_RDV_ANSWER: assert property (mg_hit |=> o_mgmt_rd_valid) else $error("mgmt read not answered");
    AST_PAD: assert property (o_reg_rdata[31:16] == 16'h0000) else $error("padding not zero");
    AST_FIXED_BITS: assert property ((o_reg_rdata[15:0] & 16'h827F) == 16'h0000 && (o_mgmt_rdata & 16'h827F) == 16'h0000) else $error("fixed bits not zero");
    AST_NO_HIT: assert property (i_reg_rd && i_reg_addr != PORT_OFFSET |=> o_reg_rdata == 32'h0) else $error("unmapped read gave data");
    AST_RST_QUIET: assert property (disable iff (1'h0) !i_resetn |=> !o_mac_col && !o_mac_rx_dv) else $error("outputs active in reset");
    C_MGMT: cover property (o_mgmt_rd_valid);
    C_COL: cover property (o_mac_col);
    C_ISO: cover property (!o_mac_out_oe);
endmodule
bind emulated_phy_control emulated_phy_control_monitor #(.PORT_OFFSET(PORT_OFFSET)) u_mon (.*);

// *** sim/mac_model.sv ***
// stand-in for the external mac: sends short nibble frames on request
`timescale 1ns/10ps
module mac_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_send,
    output logic      [3:0] o_txd,
    output logic            o_tx_en
);
    logic [3:0] left = 4'h0;
    initial o_txd = 4'h0;
    initial o_tx_en = 1'h0;
    // data toggles every cycle so a stale or unknown nibble never passes
    always @(posedge i_ref_clk)
    begin
        left <= i_send ? 4'h6 : (left != 4'h0 ? left - 4'h1 : 4'h0);
        o_tx_en <= left != 4'h0;
        o_txd <= ~o_txd + 4'h3;
    end
endmodule

// *** sim/virtual_phy_basic_control_tb_top.sv ***
// self-checking bench for the emulated phy control register
`timescale 1ns/10ps
module virtual_phy_basic_control_tb_top;
    localparam logic [11:0] OFS = 12'h1C0;
    logic i_ref_clk = 1'h0, i_resetn = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, send = 1'h0;
    logic i_mgmt_wr = 1'h0, i_mgmt_rd = 1'h0, i_mgmt_data_in = 1'h0, i_mgmt_drive = 1'h0;
    logic i_mac_mode = 1'h0, i_rmii_mode = 1'h0, i_pin_duplex = 1'h0, i_pin_speed = 1'h0;
    logic [11:0] i_reg_addr = 12'h000;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, rd;
    logic [4:0] i_mgmt_phy_addr = 5'h00, i_mgmt_reg_index = 5'h00, i_phy_addr_strap = 5'h03;
    logic [15:0] i_mgmt_wdata = 16'h0000, o_mgmt_rdata;
    logic o_mgmt_rd_valid, o_mgmt_data_out, o_mgmt_data_oe, o_mac_rx_dv, o_mac_col;
    logic o_mac_out_oe, o_pull_enable, o_fabric_tx_en, i_mac_tx_en, i_fabric_rx_dv = 1'h0;
    logic [3:0] i_mac_txd, o_mac_rxd, o_fabric_txd, t, i_fabric_rxd = 4'h5;
    emulated_phy_pkg::link_mode_t o_link_mode;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    logic [31:0] row_wr [7] = '{32'h1000, 32'h0, 32'h2100, 32'h2000, 32'h0100, 32'hFFFF7FFF, 32'h0800};
    logic [15:0] row_rd [7] = '{16'h1000, 16'h0, 16'h2100, 16'h2000, 16'h0100, 16'h7D80, 16'h0800};
    logic [1:0] row_lm [7] = '{2'h3, 2'h0, 2'h3, 2'h2, 2'h1, 2'h3, 2'h0};

    emulated_phy_control #(.PORT_OFFSET(OFS)) u_dut (.*);
    mac_model u_mac (.i_ref_clk(i_ref_clk), .i_send(send), .o_txd(i_mac_txd), .o_tx_en(i_mac_tx_en));
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
        @(posedge i_ref_clk);
        {i_reg_wr, i_reg_rd} <= 2'h0;
        @(negedge i_ref_clk);
        rd = o_reg_rdata;
    endtask
    task automatic mg(input logic w, input logic [4:0] pa, input logic [4:0] ix, input logic [15:0] d);
        @(posedge i_ref_clk);
        {i_mgmt_wr, i_mgmt_rd, i_mgmt_phy_addr, i_mgmt_reg_index, i_mgmt_wdata} <= {w, !w, pa, ix, d};
        @(posedge i_ref_clk);
        {i_mgmt_wr, i_mgmt_rd} <= 2'h0;
        @(negedge i_ref_clk);
        rd = {o_mgmt_rd_valid, 15'h0, o_mgmt_rdata};
    endtask
    task automatic frame(input logic [2:0] exp);
        @(posedge i_ref_clk);
        send <= 1'h1;
        @(posedge i_ref_clk);
        send <= 1'h0;
        repeat (3) @(negedge i_ref_clk);
        chk({o_mac_rx_dv, o_fabric_tx_en, o_mac_col}, exp);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // sequence
    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        bus(0, OFS, 0);
        chk(rd, 32'h1000);
        for (int i = 0; i < 7; i++)
        begin
            bus(1, OFS, row_wr[i]);
            bus(0, OFS, 0);
            chk(rd, {16'h0, row_rd[i]});
            mg(0, 5'h03, 5'h00, 0);
            chk(rd, {16'h8000, row_rd[i]});
            chk(o_link_mode, row_lm[i]);
        end
        $display("row tests done");
        bus(1, OFS, 32'h6180);
        bus(1, OFS, 32'h8000);
        bus(0, OFS, 0);
        chk(rd, 32'h1000);
        repeat (3) @(negedge i_ref_clk);
        chk(o_link_mode, 2'h3);
        bus(1, OFS, 32'h0200);
        bus(0, OFS, 0);
        chk(rd, 32'h0);
        mg(1, 5'h03, 5'h00, 16'h2100);
        bus(0, OFS, 0);
        chk(rd, 32'h2100);
        mg(0, 5'h04, 5'h00, 0);
        chk(rd[31], 1'h0);
        mg(0, 5'h03, 5'h01, 0);
        chk(rd[31], 1'h0);
        bus(0, 12'h1C4, 0);
        chk(rd, 32'h0);
        $display("access tests done");
        // collision test only inside loopback, as software is advised
        bus(1, OFS, 32'h4080);
        frame(3'h5);
        @(negedge i_ref_clk);
        t = i_mac_txd;
        @(negedge i_ref_clk);
        chk(o_mac_rxd, t);
        repeat (8) @(posedge i_ref_clk);
        bus(1, OFS, 32'h0);
        frame(3'h2);
        $display("datapath tests done");
        bus(1, OFS, 32'h1400);
        {i_mgmt_drive, i_mgmt_data_in} <= 2'h3;
        @(negedge i_ref_clk);
        chk({o_mac_out_oe, o_pull_enable, o_mgmt_data_out, o_mgmt_data_oe}, 4'h3);
        {i_mac_mode, i_rmii_mode} <= 2'h3;
        repeat (3) @(negedge i_ref_clk);
        chk({o_mac_out_oe, o_pull_enable}, 2'h3);
        chk(o_link_mode, 2'h0);
        {i_pin_speed, i_pin_duplex} <= 2'h3;
        repeat (3) @(negedge i_ref_clk);
        chk(o_link_mode, 2'h3);
        bus(1, OFS, 32'h0);
        repeat (3) @(negedge i_ref_clk);
        chk(o_link_mode, 2'h0);
        $display("pin tests done");
        stop_test();
    end
endmodule
